// ==== core/i2srs_dev.sv ====
// Purpose: serial RAM slave end, 256 x 8 with auto-increment pointer
// Assumes: scl/sda sampled by clk_sys, far slower than clk_sys
// Notes: write data passes an 8-word fifo before the array
`timescale 1ns/1ps
`include "i2srs_regs.svh"
// Function
// - idle when both lines high
// - one bit per scl pulse, stable high
// - sda fall with scl high starts
// - sda rise with scl high stops
// - no limit on bytes per transfer
// - ninth clock carries acknowledge
// - transmitter releases sda at acknowledge
// - addressed receiver acknowledges every byte; here a full fifo withholds the ack on pointer and data bytes
// - master acknowledges read bytes until last
// - acknowledger holds sda low whole pulse
// - master ends read with no acknowledge
// - after no acknowledge release sda high
// - first byte after start is address
// - three straps form address bits
// - power-save input low in operation
// - scl input only, sda low only
// - pointer increments after each data byte
// - upper four bits match device code
// - power-save resets bus logic
// - power-on reset resets bus logic
module i2srs_dev
  import i2srs_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic power_save,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  output logic busy,
  i2srs_if.dev bus
);
  logic [7:0] mem [256];
  logic rst_n;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic ps_m_q, ps_s_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  i2srs_dev_state_t st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic addr_ph_q, ptr_ph_q, rd_q, sel_q, drv_q, nack_q;
  logic [7:0] ptr_q;
  logic [2:0] strap_m_q, strap_s_q;
  logic f_valid, f_ready, o_valid;
  logic [15:0] f_data;
  logic [15:0] o_data;
  logic [7:0] dev_addr;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ps_m_q <= 1'b0;
      ps_s_q <= 1'b0;
    end else begin
      ps_m_q <= power_save;
      ps_s_q <= ps_m_q;
    end
  end
  // power-on and power-save both clear the bus logic
  assign rst_n = resetn & ~ps_s_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {bus.scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {bus.sda, sda_m_q, sda_s_q};
    end
  end
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // sda moves with scl high are controls, not data
  assign start_ev = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  assign stop_ev = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;
  assign busy = (st_q != I2SRS_S_IDLE);

  // straps are pins, so they pass two flops like the bus lines
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
    end else begin
      strap_m_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_s_q <= strap_m_q;
    end
  end
  assign dev_addr = {`I2SRS_DEV_CODE, strap_s_q, 1'b0};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= I2SRS_S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_ph_q <= 1'b0;
      ptr_ph_q <= 1'b0;
      rd_q <= 1'b0;
      sel_q <= 1'b0;
      drv_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= `I2SRS_PTR_RESET;
    end else if (stop_ev) begin
      st_q <= I2SRS_S_IDLE;
      drv_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= I2SRS_S_RX;
      cnt_q <= 4'h0;
      addr_ph_q <= 1'b1;
      sel_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      unique case (st_q)
        I2SRS_S_IDLE: begin
          drv_q <= 1'b0;
        end
        I2SRS_S_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            if (addr_ph_q) begin
              addr_ph_q <= 1'b0;
              if (sh_q[7:1] == dev_addr[7:1]) begin
                sel_q <= 1'b1;
                rd_q <= sh_q[`I2SRS_DIR_BIT];
                ptr_ph_q <= ~sh_q[`I2SRS_DIR_BIT];
                drv_q <= 1'b1;
                st_q <= I2SRS_S_ACK;
              end else begin
                st_q <= I2SRS_S_IDLE;
              end
            end else if (sel_q) begin
              drv_q <= f_ready; // full fifo withholds ack
              st_q <= I2SRS_S_ACK;
              if (ptr_ph_q) begin
                ptr_ph_q <= 1'b0;
                ptr_q <= sh_q;
              end else if (f_ready) begin
                ptr_q <= ptr_q + 8'h01; // wraps at 255
              end
            end
          end
        end
        I2SRS_S_ACK: begin
          // ack held low through the whole ninth pulse
          if (scl_fall) begin
            if (rd_q) begin
              st_q <= I2SRS_S_TX;
              sh_q <= mem[ptr_q];
              drv_q <= ~mem[ptr_q][7] ? 1'b1 : 1'b0;
              cnt_q <= 4'h1;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              st_q <= I2SRS_S_RX; // no length limit
              drv_q <= 1'b0;
            end
          end
        end
        I2SRS_S_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              drv_q <= 1'b0; // release for master ack
              st_q <= I2SRS_S_MACK;
            end else begin
              drv_q <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        I2SRS_S_MACK: begin
          if (scl_rise) begin
            nack_q <= sda_s_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= I2SRS_S_IDLE; // stay off sda
              drv_q <= 1'b0;
            end else begin
              st_q <= I2SRS_S_TX;
              sh_q <= mem[ptr_q];
              drv_q <= ~mem[ptr_q][7];
              cnt_q <= 4'h1;
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // drive low only, never high
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = drv_q;

  // write data and its address go through the fifo to the array
  assign f_valid = (st_q == I2SRS_S_RX) && scl_fall && cnt_q == 4'h8 && sel_q
    && !addr_ph_q && !ptr_ph_q && !rd_q;
  assign f_data = {ptr_q, sh_q};
  always_ff @(posedge clk_sys) begin
    if (o_valid) begin
      mem[o_data[15:8]] <= o_data[7:0];
    end
  end

  i2srs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .resetn(rst_n),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(o_valid),
    .out_ready(1'b1),
    .out_data(o_data)
  );
endmodule

// ==== core/i2srs_fifo.sv ====
// Purpose: small fifo with valid/ready on both sides
// Assumes: DEPTH a power of two
// Notes: one word in, one out per cycle
`timescale 1ns/1ps
module i2srs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wp_q <= '0;
    end else if (in_valid && !full) begin
      wp_q <= wp_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rp_q <= '0;
    end else if (out_ready && !empty) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// ==== core/i2srs_host.sv ====
// Purpose: bus master end, issues byte writes and reads of the RAM
// Assumes: one command at a time on the user side
// Notes: scl made here from a clk_sys divider
`timescale 1ns/1ps
`include "i2srs_regs.svh"
module i2srs_host
  import i2srs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_dev,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack,
  i2srs_if.host bus
);
  localparam int HALF = `I2SRS_SCL_HALF;
  i2srs_host_state_t st_q;
  logic [15:0] div_q;
  logic tick;
  logic scl_q, sda_q, phase_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q, rd_q;
  logic rdop_q, nack_q;
  logic sda_m_q, sda_s_q;
  logic scl_m_q, scl_s_q;
  logic [6:0] dev_q;
  logic [7:0] ptr_q, wd_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= (div_q == 16'(HALF - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'(HALF - 1));
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
    end else begin
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
      scl_m_q <= bus.scl;
      scl_s_q <= scl_m_q;
    end
  end
  assign cmd_ready = (st_q == I2SRS_M_IDLE) && scl_s_q && sda_s_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= I2SRS_M_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      phase_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      rdop_q <= 1'b0;
      nack_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_nack <= 1'b0;
      dev_q <= 7'h00;
      ptr_q <= 8'h00;
      wd_q <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        I2SRS_M_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            rdop_q <= cmd_read;
            // command fields held here, the user side may move on
            dev_q <= cmd_dev;
            ptr_q <= cmd_ptr;
            wd_q <= cmd_wdata;
            sh_q <= {cmd_dev, 1'b0};
            byte_q <= 2'h0;
            nack_q <= 1'b0;
            sda_q <= 1'b0; // start with scl high
            st_q <= I2SRS_M_START;
          end
        end
        I2SRS_M_START, I2SRS_M_RSTART: begin
          if (tick) begin
            if (st_q == I2SRS_M_RSTART && !scl_q) begin
              scl_q <= 1'b1;
            end else if (st_q == I2SRS_M_RSTART && sda_q) begin
              sda_q <= 1'b0; // repeated start for the read
            end else begin
              scl_q <= 1'b0;
              bit_q <= 4'h0;
              phase_q <= 1'b0;
              st_q <= I2SRS_M_BIT;
            end
          end
        end
        I2SRS_M_BIT: begin
          // sda changes only while scl low
          if (tick) begin
            if (!phase_q) begin
              sda_q <= (byte_q == 2'h3) ? 1'b1 : sh_q[7];
              phase_q <= 1'b1;
            end else if (!scl_q) begin
              scl_q <= 1'b1;
            end else begin
              scl_q <= 1'b0;
              rd_q <= {rd_q[6:0], sda_s_q};
              sh_q <= {sh_q[6:0], 1'b0};
              phase_q <= 1'b0;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                st_q <= I2SRS_M_ACK;
              end
            end
          end
        end
        I2SRS_M_ACK: begin
          if (tick) begin
            if (!phase_q) begin
              // release to read ack; as reader send no ack on the one byte
              sda_q <= 1'b1;
              phase_q <= 1'b1;
            end else if (!scl_q) begin
              scl_q <= 1'b1;
            end else begin
              scl_q <= 1'b0;
              phase_q <= 1'b0;
              if (byte_q != 2'h3 && sda_s_q) begin
                nack_q <= 1'b1;
              end
              st_q <= I2SRS_M_NEXT;
            end
          end
        end
        I2SRS_M_NEXT: begin
          if (nack_q || byte_q == 2'h3 || (byte_q == 2'h2 && !rdop_q)) begin
            sda_q <= 1'b0;
            st_q <= I2SRS_M_STOP;
          end else if (byte_q == 2'h1 && rdop_q) begin
            // byte 2 is the read address here, byte 3 the data read back
            sh_q <= {dev_q, 1'b1};
            byte_q <= 2'h2;
            st_q <= I2SRS_M_RSTART;
          end else begin
            sh_q <= (byte_q == 2'h0) ? ptr_q : wd_q;
            byte_q <= byte_q + 2'h1;
            bit_q <= 4'h0;
            st_q <= I2SRS_M_BIT;
          end
        end
        I2SRS_M_STOP: begin
          if (tick) begin
            if (!scl_q) begin
              scl_q <= 1'b1;
            end else begin
              sda_q <= 1'b1;
              st_q <= I2SRS_M_DONE;
            end
          end
        end
        I2SRS_M_DONE: begin
          if (tick) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= rd_q;
            rsp_nack <= nack_q;
            st_q <= I2SRS_M_IDLE;
          end
        end
      endcase
    end
  end
  // open-drain outputs: enable only to pull low
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~scl_q;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = ~sda_q;
endmodule

// ==== pkg/i2srs_if.sv ====
// Purpose: two-wire bus between host and serial RAM
// Assumes: pull-ups on both lines
// Notes: wired-and of the low drives
`timescale 1ns/1ps
interface i2srs_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_host_oe & ~sda_host_o) & ~(sda_dev_oe & ~sda_dev_o);
  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
    input scl, input sda);
  modport dev (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface

// ==== pkg/i2srs_pkg.sv ====
// Purpose: shared types for the serial RAM link
// Assumes: nothing
// Notes: one-hot state codes
package i2srs_pkg;
  typedef enum logic [4:0] {
    I2SRS_S_IDLE = 5'h01,
    I2SRS_S_RX = 5'h02,
    I2SRS_S_ACK = 5'h04,
    I2SRS_S_TX = 5'h08,
    I2SRS_S_MACK = 5'h10
  } i2srs_dev_state_t;
  typedef enum logic [7:0] {
    I2SRS_M_IDLE = 8'h01,
    I2SRS_M_START = 8'h02,
    I2SRS_M_BIT = 8'h04,
    I2SRS_M_ACK = 8'h08,
    I2SRS_M_STOP = 8'h10,
    I2SRS_M_DONE = 8'h20,
    I2SRS_M_NEXT = 8'h40,
    I2SRS_M_RSTART = 8'h80
  } i2srs_host_state_t;
endpackage

// ==== pkg/i2srs_regs.svh ====
// Purpose: constants for the serial RAM link, both ends
// Assumes: one 10 MHz system clock at each end
// Notes: device-type code is an arbitrary neutral value
`ifndef I2SRS_REGS_SVH
`define I2SRS_REGS_SVH
`define I2SRS_DEV_CODE 4'h6
`define I2SRS_DEV_CODE_MSB 7
`define I2SRS_DEV_CODE_LSB 4
`define I2SRS_STRAP_MSB 3
`define I2SRS_STRAP_LSB 1
`define I2SRS_DIR_BIT 0
`define I2SRS_CLK_HZ 10000000
`define I2SRS_SCL_HZ 100000
`define I2SRS_SCL_HALF ((`I2SRS_CLK_HZ / `I2SRS_SCL_HZ) / 2)
`define I2SRS_PTR_RESET 8'h00
`endif

// ==== tb/i2srs_asserts.sv ====
// Purpose: concurrent checks on the two-wire link between host and RAM end
// Assumes: lines sampled on clk_sys, scl far slower than clk_sys
// Notes: helper registers track scl pulses inside a frame
`timescale 1ns/1ps
`include "i2srs_regs.svh"
module i2srs_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int HALF = `I2SRS_SCL_HALF;
  logic scl_q;
  logic sda_q;
  logic [3:0] bcnt_q;
  int hcnt_q;
  logic start_w;
  logic stop_w;
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // one spare pulse follows each group of nine before start or stop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bcnt_q <= 4'h1;
    end else if (start_w) begin
      bcnt_q <= 4'h0;
    end else if (scl && !scl_q) begin
      bcnt_q <= (bcnt_q == 4'h8) ? 4'h0 : bcnt_q + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hcnt_q <= HALF;
    end else if (scl != scl_q) begin
      hcnt_q <= 1;
    end else if (hcnt_q < HALF) begin
      hcnt_q <= hcnt_q + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  dev_low_only_a: assert property (sda_dev_o == 1'h0)
    else $error("device drives sda high");
  host_low_only_a: assert property (scl_o == 1'h0 && sda_host_o == 1'h0)
    else $error("host drives a line high");
  dev_stable_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device sda changed while scl high");
  ack_release_a: assert property (scl |-> !(sda_host_oe && sda_dev_oe))
    else $error("both ends pull sda while scl high");
  stop_quiet_a: assert property (stop_w |=> !sda_dev_oe [*8])
    else $error("device drives sda after stop");
  dev_setup_low_a: assert property ($rose(sda_dev_oe) |-> !scl && !$past(scl, 3))
    else $error("device pulled sda too near scl high");
  scl_pace_a: assert property (scl != scl_q |-> hcnt_q >= HALF - 1)
    else $error("scl half period too short");
  ninth_bound_a: assert property (start_w || stop_w |-> bcnt_q == 4'h1)
    else $error("start or stop inside a byte slot");
  cover property (start_w);
  cover property (stop_w);
  cover property (scl && sda_dev_oe);
endmodule

// ==== tb/i2srs_tb.sv ====
// Purpose: host end and RAM end joined by the bus, driven from host user side
// Assumes: scl paced by the header half period, three of them per bit, so each frame takes many clk_sys cycles
// Notes: few frames only, to keep run time down
`timescale 1ns/1ps
`include "i2srs_regs.svh"
module i2srs_tb;
  localparam int LIMIT = 40000;
  localparam logic [6:0] DEV_ADDR = {`I2SRS_DEV_CODE, 3'h5};
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic power_save = 1'h0;
  logic [2:0] strap = 3'h5;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic [6:0] cmd_dev = 7'h00;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic busy;
  logic [7:0] rsp_rdata;
  logic [7:0] got_data;
  logic got_nack;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  i2srs_if i_i2srs_if ();
  i2srs_host i_i2srs_host (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_ptr(cmd_ptr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_nack(rsp_nack), .bus(i_i2srs_if));
  i2srs_dev i_i2srs_dev (.clk_sys(clk_sys), .resetn(resetn), .power_save(power_save),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .busy(busy), .bus(i_i2srs_if));
  i2srs_asserts i_i2srs_asserts (.clk_sys(clk_sys), .resetn(resetn),
    .scl_o(i_i2srs_if.scl_o), .scl_oe(i_i2srs_if.scl_oe),
    .sda_host_o(i_i2srs_if.sda_host_o), .sda_host_oe(i_i2srs_if.sda_host_oe),
    .sda_dev_o(i_i2srs_if.sda_dev_o), .sda_dev_oe(i_i2srs_if.sda_dev_oe),
    .scl(i_i2srs_if.scl), .sda(i_i2srs_if.sda));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("cycle limit reached");
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one command, offered for one cycle once ready, then wait for the response and idle
  task automatic do_cmd(input logic rd, input logic [6:0] dev, input logic [7:0] ptr,
      input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'h1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit("command ready", 1'h1, cmd_ready);
    cmd_valid = 1'h1;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_ptr = ptr;
    cmd_wdata = wd;
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit("response", 1'h1, rsp_valid);
    got_data = rsp_rdata;
    got_nack = rsp_nack;
    n = 0;
    while (busy !== 1'h0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic t_write;
    do_cmd(1'h0, DEV_ADDR, 8'hFF, 8'hA5);
    chk_bit("write nack", 1'h0, got_nack);
    chk_bit("busy after stop", 1'h0, busy);
    $display("test write done");
  endtask
  task automatic t_bad_addr;
    do_cmd(1'h0, {`I2SRS_DEV_CODE, 3'h2}, 8'h10, 8'h77);
    chk_bit("strap mismatch nack", 1'h1, got_nack);
    do_cmd(1'h0, {`I2SRS_DEV_CODE ^ 4'h1, 3'h5}, 8'h10, 8'h77);
    chk_bit("code mismatch nack", 1'h1, got_nack);
    $display("test wrong address done");
  endtask
  // power save cuts a write mid-frame; memory survives, only bus logic resets
  task automatic t_read_after_save;
    fork
      do_cmd(1'h0, DEV_ADDR, 8'hFF, 8'h3C);
      begin
        wait (busy === 1'h1);
        @(negedge clk_sys);
        power_save = 1'h1;
        repeat (10) @(negedge clk_sys);
        chk_bit("busy in power save", 1'h0, busy);
        power_save = 1'h0;
      end
    join
    chk_bit("nack after power save", 1'h1, got_nack);
    repeat (10) @(negedge clk_sys);
    do_cmd(1'h1, DEV_ADDR, 8'hFF, 8'h00);
    chk_bit("read nack", 1'h0, got_nack);
    chk_byte("read data", 8'hA5, got_data);
    $display("test read after power save done");
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'h1;
    t_write();
    t_bad_addr();
    t_read_after_save();
    summarize();
  end
endmodule
